//--- rtl/usbsi_pkg.sv
// constants of the interface configuration command bank
package usbsi_pkg;

  // ==========================================================
  // command addresses
  localparam logic [5:0] ADDR_INTERFACE_CONFIG   = 6'h01;
  localparam logic [5:0] ADDR_INTERRUPT_ENABLE   = 6'h2e;
  localparam logic [5:0] ADDR_DESCRIPTOR_RAM     = 6'h30;
  localparam logic [5:0] ADDR_CONTROL_BUFFER     = 6'h31;
  localparam logic [5:0] ADDR_CONTROL_SETUP      = 6'h32;
  localparam logic [5:0] ADDR_CONTROL_BYTE_COUNT = 6'h33;
  localparam logic [5:0] ADDR_POINTER_LOW        = 6'h3a;
  localparam logic [5:0] ADDR_POINTER_HIGH       = 6'h3b;
  localparam logic [5:0] ADDR_INDIRECT_DATA      = 6'h3c;

  // ==========================================================
  // command byte layout
  localparam int unsigned CMD_ADDR_MSB = 5;
  localparam int unsigned CMD_READ_BIT = 6;

  // ==========================================================
  // interface_config fields and reset value
  localparam int unsigned CFG_CLOCK_SOURCE = 7;
  localparam int unsigned CFG_SPEED_48     = 6;
  localparam int unsigned CFG_CLOCK_OE     = 5;
  localparam int unsigned CFG_CLOCK_INVERT = 4;
  localparam int unsigned CFG_STROBE_STROBE_MODE_SELECT = 3;
  localparam int unsigned CFG_STANDBY      = 2;
  localparam int unsigned CFG_FLAG_SELECT  = 1;
  localparam int unsigned CFG_DISCONNECT   = 0;
  localparam logic [7:0]  CONFIG_RESET     = 8'hc9;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;

  // ==========================================================
  // internal fifo clock divider, half periods in system cycles
  localparam logic [3:0] HALF_PERIOD_30 = 4'h3;
  localparam logic [3:0] HALF_PERIOD_48 = 4'h2;

  // ==========================================================
  // state encodings
  typedef enum logic [2:0] {
    CMD_IDLE = 3'b001,
    CMD_HIGH = 3'b010,
    CMD_LOW  = 3'b100
  } usbsi_cmd_state_type;

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b01,
    PWR_STANDBY = 2'b10
  } usbsi_power_state_type;

endpackage

//--- rtl/usbsi_cfg_if.sv
// configuration fields and clock status between bank and clock unit
`timescale 1ns/1ps
interface usbsi_cfg_if;
  logic clock_source;
  logic speed_48;
  logic clock_oe;
  logic clock_invert;
  logic standby_request;
  logic osc_enable;
  logic fifo_edge;
  logic clock_pin;
  logic clock_pin_oe;

  modport bank (
    output clock_source,
    output speed_48,
    output clock_oe,
    output clock_invert,
    output standby_request,
    input  osc_enable,
    input  fifo_edge,
    input  clock_pin,
    input  clock_pin_oe
  );

  modport clocking_unit (
    input  clock_source,
    input  speed_48,
    input  clock_oe,
    input  clock_invert,
    input  standby_request,
    output osc_enable,
    output fifo_edge,
    output clock_pin,
    output clock_pin_oe
  );
endinterface

//--- rtl/usbsi_clock_unit.sv
// fifo clock source, clock pin driver and standby control
`timescale 1ns/1ps
module usbsi_clock_unit (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ext_clock_pin,
  input  wire logic             wake_sync,
  input  wire logic             bus_activity,
  usbsi_cfg_if.clocking_unit    cfg
);

  // ==========================================================
  // standby
  usbsi_pkg::usbsi_power_state_type power_state;
  logic osc_enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= usbsi_pkg::PWR_RUN;
      osc_enable  <= 1'b1;
    end else begin
      case (power_state)
        usbsi_pkg::PWR_RUN: begin
          if (cfg.standby_request) begin
            power_state <= usbsi_pkg::PWR_STANDBY;
            osc_enable  <= 1'b0;
          end
        end
        usbsi_pkg::PWR_STANDBY: begin
          if (wake_sync || bus_activity) begin
            power_state <= usbsi_pkg::PWR_RUN;
            osc_enable  <= 1'b1;
          end
        end
        default: begin
          power_state <= usbsi_pkg::PWR_RUN;
          osc_enable  <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // internal clock divider, halted while the oscillator is off
  logic [3:0] div_count;
  logic       int_clock;
  logic [3:0] half_period;

  assign half_period = cfg.speed_48 ? usbsi_pkg::HALF_PERIOD_48 : usbsi_pkg::HALF_PERIOD_30;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 4'h0;
      int_clock <= 1'b0;
    end else if (osc_enable) begin
      if (div_count >= half_period - 4'h1) begin
        div_count <= 4'h0;
        int_clock <= ~int_clock;
      end else begin
        div_count <= div_count + 4'h1;
      end
    end
  end

  // ==========================================================
  // clock pin driver
  logic clock_pin;
  logic clock_pin_oe;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_pin    <= 1'b0;
      clock_pin_oe <= 1'b0;
    end else begin
      clock_pin    <= int_clock ^ cfg.clock_invert;
      clock_pin_oe <= cfg.clock_oe;
    end
  end

  // ==========================================================
  // active edge of the selected fifo clock
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic int_prev;
  logic fifo_edge;
  logic ext_edge;
  logic int_edge;

  assign ext_edge = cfg.clock_invert ? (ext_s3 & ~ext_s2) : (~ext_s3 & ext_s2);
  assign int_edge = cfg.clock_invert ? (int_prev & ~int_clock) : (~int_prev & int_clock);

  // pick external pin or internal clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      ext_s3    <= 1'b0;
      int_prev  <= 1'b0;
      fifo_edge <= 1'b0;
    end else begin
      ext_s1    <= ext_clock_pin;
      ext_s2    <= ext_s1;
      ext_s3    <= ext_s2;
      int_prev  <= int_clock;
      fifo_edge <= cfg.clock_source ? int_edge : ext_edge;
    end
  end

  assign cfg.osc_enable   = osc_enable;
  assign cfg.fifo_edge    = fifo_edge;
  assign cfg.clock_pin    = clock_pin;
  assign cfg.clock_pin_oe = clock_pin_oe;

endmodule // usbsi_clock_unit

//--- rtl/usbsi_config_bank.sv
// command register bank with interface configuration and indirect access
//
// Behaviour
// - config bit 7 selects fifo clock: 0 external pin, 1 internal (default).
// - config bit 6 selects internal clock 30 MHz (0) or 48 MHz (1, default).
// - config bit 5 set drives device clock onto the clock pin; clear floats it.
// - config bit 4 set inverts clock so the falling edge is active.
// - config bit 3 clear: fifo controls are enables sampled on the active edge.
// - config bit 3 set (default): fifo controls act directly as strobes.
// - writing 1 to config bit 2 stops the oscillator for low power.
// - suspended device wakes on USB bus activity or the wake pin.
// - config bit 1 clear: shared pin is chip select; set: fourth flag output.
// - config bit 0 set floats the D+ pull-up; clear drives it high.
// - low bits of the pointer at 3a select an indirect register, 3b is only stored; 3c moves its data.
`timescale 1ns/1ps
module usbsi_config_bank #(
  parameter int unsigned INDIRECT_DEPTH = 16
) (
  // clock and reset
  input  wire logic       CLOCK_IN,
  input  wire logic       ARST_N_IN,
  // command port pins
  input  wire logic       CMD_STROBE_N_IN,
  input  wire logic       CMD_ADDR_SEL_IN,
  input  wire logic [7:0] CMD_DATA_IN,
  output logic      [7:0] READ_DATA_OUT,
  output logic            READ_VALID_OUT,
  // fifo control pins
  input  wire logic       FIFO_READ_N_IN,
  input  wire logic       FIFO_WRITE_N_IN,
  output logic            FIFO_READ_OUT,
  output logic            FIFO_WRITE_OUT,
  // interface clock pin
  input  wire logic       INTERFACE_CLOCK_PIN_IN,
  output logic            INTERFACE_CLOCK_PIN_OUT,
  output logic            INTERFACE_CLOCK_PIN_OE_OUT,
  // shared flag or chip select pin
  input  wire logic       FLAG_OR_SELECT_PIN_IN,
  input  wire logic       FIFO_FLAG_D_IN,
  output logic            FLAG_OR_SELECT_PIN_OUT,
  output logic            FLAG_OR_SELECT_PIN_OE_OUT,
  // usb side
  input  wire logic       BUS_ACTIVITY_IN,
  input  wire logic       WAKE_PIN_N_IN,
  output logic            PULLUP_OUT,
  output logic            PULLUP_OE_OUT,
  // status and configuration
  output logic            OSC_ENABLE_OUT,
  output logic            INTERNAL_CLOCK_48M_OUT,
  output logic            FIFO_CLOCK_INTERNAL_OUT,
  output logic            STROBE_MODE_STROBE_MODE_SELECT_OUT,
  output logic      [7:0] INTERRUPT_ENABLE_OUT,
  output logic            DESCRIPTOR_RAM_PORT_WRITE_OUT,
  output logic      [7:0] DESCRIPTOR_RAM_PORT_DATA_OUT
);

  localparam int unsigned IDX_W = $clog2(INDIRECT_DEPTH);

  // ==========================================================
  // parameter check
  generate
    if (INDIRECT_DEPTH < 2 || INDIRECT_DEPTH > 256 || (1 << IDX_W) != INDIRECT_DEPTH) begin : g_bad_depth
      $error("INDIRECT_DEPTH must be a power of two from 2 to 256");
    end
  endgenerate

  function automatic logic addr_is(input logic [5:0] a, input logic [5:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [9:0] cmd_s1;
  logic [9:0] cmd_s2;
  logic       strobe_n_prev;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic       rd_n_prev;
  logic       wr_n_prev;

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_s1        <= 10'h200;
      cmd_s2        <= 10'h200;
      strobe_n_prev <= 1'b1;
      pin_s1        <= 5'h1f;
      pin_s2        <= 5'h1f;
      rd_n_prev     <= 1'b1;
      wr_n_prev     <= 1'b1;
    end else begin
      cmd_s1        <= {CMD_STROBE_N_IN, CMD_ADDR_SEL_IN, CMD_DATA_IN};
      cmd_s2        <= cmd_s1;
      strobe_n_prev <= cmd_s2[9];
      pin_s1        <= {FIFO_READ_N_IN, FIFO_WRITE_N_IN, FLAG_OR_SELECT_PIN_IN, WAKE_PIN_N_IN, 1'b1};
      pin_s2        <= pin_s1;
      rd_n_prev     <= pin_s2[4];
      wr_n_prev     <= pin_s2[3];
    end
  end

  logic       cmd_event;
  logic       cmd_is_addr;
  logic [7:0] cmd_byte;
  assign cmd_event   = strobe_n_prev & ~cmd_s2[9];
  assign cmd_is_addr = cmd_s2[8];
  assign cmd_byte    = cmd_s2[7:0];

  // ==========================================================
  // command sequencer
  usbsi_pkg::usbsi_cmd_state_type cmd_state;
  logic [5:0] cur_addr;
  logic [3:0] upper_nibble;
  logic       write_commit;
  logic [7:0] write_byte;
  logic       read_request;

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_state    <= usbsi_pkg::CMD_IDLE;
      cur_addr     <= 6'h00;
      upper_nibble <= 4'h0;
      write_commit <= 1'b0;
      write_byte   <= 8'h00;
      read_request <= 1'b0;
    end else begin
      write_commit <= 1'b0;
      read_request <= 1'b0;
      if (cmd_event && cmd_is_addr) begin
        cur_addr     <= cmd_byte[usbsi_pkg::CMD_ADDR_MSB:0];
        read_request <= cmd_byte[usbsi_pkg::CMD_READ_BIT];
        cmd_state    <= usbsi_pkg::CMD_HIGH;
      end else if (cmd_event) begin
        case (cmd_state)
          usbsi_pkg::CMD_HIGH: begin
            upper_nibble <= cmd_byte[3:0];
            cmd_state    <= usbsi_pkg::CMD_LOW;
          end
          usbsi_pkg::CMD_LOW: begin
            write_byte   <= {upper_nibble, cmd_byte[3:0]};
            write_commit <= 1'b1;
            cmd_state    <= usbsi_pkg::CMD_HIGH;
          end
          usbsi_pkg::CMD_IDLE: begin
            cmd_state <= usbsi_pkg::CMD_IDLE;
          end
          default: begin
            cmd_state <= usbsi_pkg::CMD_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // register file
  logic [7:0] interface_config;
  logic [7:0] interrupt_enable;
  logic [7:0] control_endpoint_buffer;
  logic [7:0] control_setup_stall;
  logic [7:0] control_byte_count;
  logic [7:0] indirect_pointer_low;
  logic [7:0] indirect_pointer_high;
  logic [7:0] indirect_mem [INDIRECT_DEPTH];
  logic       standby_request;
  logic [IDX_W-1:0] indirect_index;

  assign indirect_index = indirect_pointer_low[IDX_W-1:0];

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      interface_config <= usbsi_pkg::CONFIG_RESET;
      standby_request  <= 1'b0;
    end else begin
      standby_request <= 1'b0;
      if (write_commit && addr_is(cur_addr, usbsi_pkg::ADDR_INTERFACE_CONFIG)) begin
        interface_config <= write_byte;
        standby_request  <= write_byte[usbsi_pkg::CFG_STANDBY];
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      interrupt_enable        <= usbsi_pkg::BYTE_RESET;
      control_endpoint_buffer <= usbsi_pkg::BYTE_RESET;
      control_setup_stall     <= usbsi_pkg::BYTE_RESET;
      control_byte_count      <= usbsi_pkg::BYTE_RESET;
    end else if (write_commit) begin
      if (addr_is(cur_addr, usbsi_pkg::ADDR_INTERRUPT_ENABLE)) begin
        interrupt_enable <= write_byte;
      end
      if (addr_is(cur_addr, usbsi_pkg::ADDR_CONTROL_BUFFER)) begin
        control_endpoint_buffer <= write_byte;
      end
      if (addr_is(cur_addr, usbsi_pkg::ADDR_CONTROL_SETUP)) begin
        control_setup_stall <= write_byte;
      end
      if (addr_is(cur_addr, usbsi_pkg::ADDR_CONTROL_BYTE_COUNT)) begin
        control_byte_count <= write_byte;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      indirect_pointer_low  <= usbsi_pkg::BYTE_RESET;
      indirect_pointer_high <= usbsi_pkg::BYTE_RESET;
      for (int i = 0; i < INDIRECT_DEPTH; i++) begin
        indirect_mem[i] <= usbsi_pkg::BYTE_RESET;
      end
    end else if (write_commit) begin
      if (addr_is(cur_addr, usbsi_pkg::ADDR_POINTER_LOW)) begin
        indirect_pointer_low <= write_byte;
      end
      if (addr_is(cur_addr, usbsi_pkg::ADDR_POINTER_HIGH)) begin
        indirect_pointer_high <= write_byte;
      end
      if (addr_is(cur_addr, usbsi_pkg::ADDR_INDIRECT_DATA)) begin
        indirect_mem[indirect_index] <= write_byte;
      end
    end
  end

  // descriptor port is write only, each byte leaves as a pulse
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      DESCRIPTOR_RAM_PORT_WRITE_OUT <= 1'b0;
      DESCRIPTOR_RAM_PORT_DATA_OUT  <= 8'h00;
    end else begin
      DESCRIPTOR_RAM_PORT_WRITE_OUT <= write_commit && addr_is(cur_addr, usbsi_pkg::ADDR_DESCRIPTOR_RAM);
      if (write_commit && addr_is(cur_addr, usbsi_pkg::ADDR_DESCRIPTOR_RAM)) begin
        DESCRIPTOR_RAM_PORT_DATA_OUT <= write_byte;
      end
    end
  end

  // ==========================================================
  // read path, unmapped and write-only addresses read zero
  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    case (cur_addr)
      usbsi_pkg::ADDR_INTERFACE_CONFIG:   read_mux = interface_config;
      usbsi_pkg::ADDR_INTERRUPT_ENABLE:   read_mux = interrupt_enable;
      usbsi_pkg::ADDR_CONTROL_BUFFER:     read_mux = control_endpoint_buffer;
      usbsi_pkg::ADDR_CONTROL_SETUP:      read_mux = control_setup_stall;
      usbsi_pkg::ADDR_CONTROL_BYTE_COUNT: read_mux = control_byte_count;
      usbsi_pkg::ADDR_POINTER_LOW:        read_mux = indirect_pointer_low;
      usbsi_pkg::ADDR_POINTER_HIGH:       read_mux = indirect_pointer_high;
      usbsi_pkg::ADDR_INDIRECT_DATA:      read_mux = indirect_mem[indirect_index];
      default:                            read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      READ_DATA_OUT  <= 8'h00;
      READ_VALID_OUT <= 1'b0;
    end else begin
      READ_VALID_OUT <= read_request;
      if (read_request) begin
        READ_DATA_OUT <= read_mux;
      end
    end
  end

  // ==========================================================
  // clock unit
  usbsi_cfg_if cfg_bus ();

  assign cfg_bus.clock_source    = interface_config[usbsi_pkg::CFG_CLOCK_SOURCE];
  assign cfg_bus.speed_48        = interface_config[usbsi_pkg::CFG_SPEED_48];
  assign cfg_bus.clock_oe        = interface_config[usbsi_pkg::CFG_CLOCK_OE];
  assign cfg_bus.clock_invert    = interface_config[usbsi_pkg::CFG_CLOCK_INVERT];
  assign cfg_bus.standby_request = standby_request;

  usbsi_clock_unit u_clock_unit (
    .clk           (CLOCK_IN),
    .rst_n         (ARST_N_IN),
    .ext_clock_pin (INTERFACE_CLOCK_PIN_IN),
    .wake_sync     (~pin_s2[1]),
    .bus_activity  (BUS_ACTIVITY_IN),
    .cfg           (cfg_bus)
  );

  assign INTERFACE_CLOCK_PIN_OUT    = cfg_bus.clock_pin;
  assign INTERFACE_CLOCK_PIN_OE_OUT = cfg_bus.clock_pin_oe;
  assign OSC_ENABLE_OUT             = cfg_bus.osc_enable;

  // ==========================================================
  // fifo strobes, chip select and shared pin
  logic strobe_strobe_mode_select;
  logic flag_mode;
  logic selected;
  assign strobe_strobe_mode_select = interface_config[usbsi_pkg::CFG_STROBE_STROBE_MODE_SELECT];
  assign flag_mode    = interface_config[usbsi_pkg::CFG_FLAG_SELECT];
  // without a chip select pin the device is always selected
  assign selected     = flag_mode | ~pin_s2[2];

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FIFO_READ_OUT  <= 1'b0;
      FIFO_WRITE_OUT <= 1'b0;
    end else if (strobe_strobe_mode_select) begin
      FIFO_READ_OUT  <= selected & rd_n_prev & ~pin_s2[4];
      FIFO_WRITE_OUT <= selected & wr_n_prev & ~pin_s2[3];
    end else begin
      FIFO_READ_OUT  <= selected & cfg_bus.fifo_edge & ~pin_s2[4];
      FIFO_WRITE_OUT <= selected & cfg_bus.fifo_edge & ~pin_s2[3];
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FLAG_OR_SELECT_PIN_OUT    <= 1'b0;
      FLAG_OR_SELECT_PIN_OE_OUT <= 1'b0;
      PULLUP_OUT                <= 1'b0;
      PULLUP_OE_OUT             <= 1'b0;
    end else begin
      FLAG_OR_SELECT_PIN_OUT    <= FIFO_FLAG_D_IN;
      FLAG_OR_SELECT_PIN_OE_OUT <= flag_mode;
      PULLUP_OUT                <= 1'b1;
      PULLUP_OE_OUT             <= ~interface_config[usbsi_pkg::CFG_DISCONNECT];
    end
  end

  // ==========================================================
  // configuration status outputs
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      INTERNAL_CLOCK_48M_OUT  <= 1'b1;
      FIFO_CLOCK_INTERNAL_OUT <= 1'b1;
      STROBE_MODE_STROBE_MODE_SELECT_OUT   <= 1'b1;
      INTERRUPT_ENABLE_OUT    <= 8'h00;
    end else begin
      INTERNAL_CLOCK_48M_OUT  <= interface_config[usbsi_pkg::CFG_SPEED_48];
      FIFO_CLOCK_INTERNAL_OUT <= interface_config[usbsi_pkg::CFG_CLOCK_SOURCE];
      STROBE_MODE_STROBE_MODE_SELECT_OUT   <= strobe_strobe_mode_select;
      INTERRUPT_ENABLE_OUT    <= interrupt_enable;
    end
  end

endmodule // usbsi_config_bank

//--- tb/usbsi_config_monitor.sv
// checker on the pins of the configuration bank
`timescale 1ns/1ps
module usbsi_config_monitor (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  // watched pins
  input wire logic READ_VALID_OUT,
  input wire logic FIFO_READ_N_IN,
  input wire logic FIFO_WRITE_N_IN,
  input wire logic FIFO_READ_OUT,
  input wire logic FIFO_WRITE_OUT,
  input wire logic INTERFACE_CLOCK_PIN_OUT,
  input wire logic FLAG_OR_SELECT_PIN_IN,
  input wire logic FIFO_FLAG_D_IN,
  input wire logic FLAG_OR_SELECT_PIN_OUT,
  input wire logic FLAG_OR_SELECT_PIN_OE_OUT,
  input wire logic BUS_ACTIVITY_IN,
  input wire logic WAKE_PIN_N_IN,
  input wire logic PULLUP_OUT,
  input wire logic OSC_ENABLE_OUT,
  input wire logic STROBE_MODE_STROBE_MODE_SELECT_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // fifo controls count only while selected or in flag mode
  logic sel;
  assign sel = FLAG_OR_SELECT_PIN_OE_OUT | ~FLAG_OR_SELECT_PIN_IN;
  // ==========================================================
  // assertions
  a_pullup_after_reset: assert property ($past(ARST_N_IN) |-> PULLUP_OUT)
    else $error("pull-up level low after reset");
  a_flag_pin_copy: assert property ($past(ARST_N_IN) |-> FLAG_OR_SELECT_PIN_OUT == $past(FIFO_FLAG_D_IN))
    else $error("shared pin not a copy of the flag");
  a_wake_on_activity: assert property (BUS_ACTIVITY_IN |=> OSC_ENABLE_OUT)
    else $error("bus activity did not wake");
  a_wake_on_pin: assert property (!WAKE_PIN_N_IN [*5] |=> OSC_ENABLE_OUT)
    else $error("wake pin did not wake");
  // two settled cycles, the last edge may still land as the oscillator stops
  a_clock_stops: assert property (!OSC_ENABLE_OUT && !$past(OSC_ENABLE_OUT) && !$past(OSC_ENABLE_OUT, 2)
    |-> $stable(INTERFACE_CLOCK_PIN_OUT))
    else $error("fifo clock runs in standby");
  a_strobe_mode_select_strobe: assert property (STROBE_MODE_STROBE_MODE_SELECT_OUT && sel && $fell(FIFO_WRITE_N_IN) |-> ##[1:5] FIFO_WRITE_OUT)
    else $error("strobe gave no write");
  a_strobe_mode_select_single: assert property (STROBE_MODE_STROBE_MODE_SELECT_OUT && FIFO_WRITE_OUT |=> !FIFO_WRITE_OUT)
    else $error("strobe gave a long write");
  a_sync_enable: assert property ((!STROBE_MODE_STROBE_MODE_SELECT_OUT && sel && !FIFO_READ_N_IN) [*4] |-> ##[0:8] FIFO_READ_OUT)
    else $error("enable gave no read");
  a_no_select: assert property (!sel [*6] |-> !FIFO_WRITE_OUT && !FIFO_READ_OUT)
    else $error("fifo access without select");
  a_read_pulse: assert property (READ_VALID_OUT |=> !READ_VALID_OUT)
    else $error("read answer longer than a cycle");
  c_standby: cover property ($fell(OSC_ENABLE_OUT));
  c_sync_read: cover property (!STROBE_MODE_STROBE_MODE_SELECT_OUT && FIFO_READ_OUT);
  c_strobe_mode_select_write: cover property (STROBE_MODE_STROBE_MODE_SELECT_OUT && FIFO_WRITE_OUT);
endmodule // usbsi_config_monitor

bind usbsi_config_bank usbsi_config_monitor mon (.CLOCK_IN, .ARST_N_IN, .READ_VALID_OUT, .FIFO_READ_N_IN,
  .FIFO_WRITE_N_IN, .FIFO_READ_OUT, .FIFO_WRITE_OUT, .INTERFACE_CLOCK_PIN_OUT, .FLAG_OR_SELECT_PIN_IN,
  .FIFO_FLAG_D_IN, .FLAG_OR_SELECT_PIN_OUT, .FLAG_OR_SELECT_PIN_OE_OUT, .BUS_ACTIVITY_IN, .WAKE_PIN_N_IN,
  .PULLUP_OUT, .OSC_ENABLE_OUT, .STROBE_MODE_STROBE_MODE_SELECT_OUT);

//--- tb/usbsi_master_model.sv
// external master driving the command port
`timescale 1ns/1ps
module usbsi_master_model (
  // answer pins
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  // command pins
  output logic            strobe_n_out,
  output logic            addr_sel_out,
  output logic      [7:0] data_out
);
  logic        [7:0] last = 8'h00;
  int unsigned       nread = 0;
  initial begin
    strobe_n_out = 1'b1;
    addr_sel_out = 1'b0;
    data_out = 8'h00;
  end
  always @(posedge clk_in) begin
    if (rvalid_in === 1'b1) begin
      last <= rdata_in;
      nread <= nread + 1;
    end
  end
  // ==========================================================
  // one strobe, pins steady four cycles around each edge
  task automatic put(input logic sel, input logic [7:0] b);
    @(negedge clk_in);
    addr_sel_out = sel;
    data_out = b;
    repeat (4) @(negedge clk_in);
    strobe_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    strobe_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    // a released bus must not keep showing the last byte
    data_out = ~b;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    put(1'b1, {2'b00, a});
    put(1'b0, {4'h0, v[7:4]});
    put(1'b0, {4'h0, v[3:0]});
  endtask
  // no answer gives an unknown so the compare fails
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int unsigned n;
    n = nread;
    put(1'b1, {2'b01, a});
    d = (nread != n) ? last : 8'hxx;
  endtask
endmodule // usbsi_master_model

//--- tb/usbsi_config_bank_test.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module usbsi_config_bank_test;
  logic       clk = 1'b0, rst_n = 1'b0, stb_n, asel, rvalid, frd, fwr, ckout, ckoe, fout, foe, pu, puoe;
  logic       frd_n = 1'b1, fwr_n = 1'b1, ckin = 1'b0, cs_n = 1'b1, flagd = 1'b0, busact = 1'b0, wake_n = 1'b1;
  logic       osc, c48, cint, am, dwr;
  logic [7:0] cdata, rdata, ien, ddata, v, r;
  wire        fpin = foe ? fout : cs_n;
  integer     error_cnt = 0, compares = 0, nwr = 0, ndw = 0, n0, i, seed = 32'h30d5f056;
  always #50 clk = ~clk;
  always @(negedge clk) begin
    ckin <= ~ckin;
    flagd <= 1'($random(seed));
  end
  always @(posedge clk) if (fwr === 1'b1) nwr++;
  always @(posedge clk) if (dwr === 1'b1) ndw++;
  usbsi_master_model m (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .strobe_n_out(stb_n),
    .addr_sel_out(asel), .data_out(cdata));
  usbsi_config_bank dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .CMD_STROBE_N_IN(stb_n), .CMD_ADDR_SEL_IN(asel),
    .CMD_DATA_IN(cdata), .READ_DATA_OUT(rdata), .READ_VALID_OUT(rvalid), .FIFO_READ_N_IN(frd_n),
    .FIFO_WRITE_N_IN(fwr_n), .FIFO_READ_OUT(frd), .FIFO_WRITE_OUT(fwr), .INTERFACE_CLOCK_PIN_IN(ckin),
    .INTERFACE_CLOCK_PIN_OUT(ckout), .INTERFACE_CLOCK_PIN_OE_OUT(ckoe), .FLAG_OR_SELECT_PIN_IN(fpin),
    .FIFO_FLAG_D_IN(flagd), .FLAG_OR_SELECT_PIN_OUT(fout), .FLAG_OR_SELECT_PIN_OE_OUT(foe),
    .BUS_ACTIVITY_IN(busact), .WAKE_PIN_N_IN(wake_n), .PULLUP_OUT(pu), .PULLUP_OE_OUT(puoe),
    .OSC_ENABLE_OUT(osc), .INTERNAL_CLOCK_48M_OUT(c48), .FIFO_CLOCK_INTERNAL_OUT(cint),
    .STROBE_MODE_STROBE_MODE_SELECT_OUT(am), .INTERRUPT_ENABLE_OUT(ien), .DESCRIPTOR_RAM_PORT_WRITE_OUT(dwr), .DESCRIPTOR_RAM_PORT_DATA_OUT(ddata));
  // ==========================================================
  // expectations
  function automatic logic drive_pullup(input logic [7:0] c);
    return ~c[usbsi_pkg::CFG_DISCONNECT];
  endfunction
  task automatic cfg(input logic [7:0] c);
    m.wr(usbsi_pkg::ADDR_INTERFACE_CONFIG, c);
    m.rd(usbsi_pkg::ADDR_INTERFACE_CONFIG, r);
    `CHK("config", c, r)
    `CHK("clock source", c[7], cint)
    `CHK("clock speed", c[6], c48)
    `CHK("clock pin oe", c[5], ckoe)
    `CHK("strobe mode", c[3], am)
    `CHK("oscillator", ~c[2], osc)
    `CHK("shared pin oe", c[1], foe)
    `CHK("pull-up oe", drive_pullup(c), puoe)
  endtask
  // a low phase of one fifo control, then idle long enough to settle
  task automatic fifo(input logic wr, input int n);
    @(negedge clk);
    if (wr) fwr_n = 1'b0; else frd_n = 1'b0;
    repeat (n) @(negedge clk);
    fwr_n = 1'b1;
    frd_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    m.rd(usbsi_pkg::ADDR_INTERFACE_CONFIG, r);
    `CHK("config reset", usbsi_pkg::CONFIG_RESET, r)
    `CHK("pull-up reset", 1'b0, puoe)
    // corners first, then random settings without standby
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hfb : 8'($random(seed));
      cfg(v & 8'hfb);
    end
    // two indirect places, re-pointed before read back
    for (i = 0; i < 2; i++) begin
      m.wr(usbsi_pkg::ADDR_POINTER_LOW, 8'h05 + 8'(i));
      m.wr(usbsi_pkg::ADDR_POINTER_HIGH, 8'he6);
      m.wr(usbsi_pkg::ADDR_INDIRECT_DATA, 8'h5a ^ 8'(i));
    end
    for (i = 0; i < 2; i++) begin
      m.wr(usbsi_pkg::ADDR_POINTER_LOW, 8'h05 + 8'(i));
      m.rd(usbsi_pkg::ADDR_INDIRECT_DATA, r);
      `CHK("indirect data", 8'h5a ^ 8'(i), r)
    end
    m.rd(6'h05, r);
    `CHK("unmapped read", 8'h00, r)
    for (i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      m.wr(6'h2e + 6'(i + (i > 0)), v);
      m.rd(6'h2e + 6'(i + (i > 0)), r);
      `CHK("register", (i == 1) ? 8'h00 : v, r)
      if (i == 0) `CHK("interrupt enable", v, ien)
      if (i == 1) `CHK("descriptor", v, ddata)
    end
    `CHK("descriptor_ram_port writes", 1, ndw)
    cfg(8'hca);
    n0 = nwr;
    fifo(1'b1, 4);
    `CHK("strobe writes", 1, nwr - n0)
    cfg(8'hc8);
    n0 = nwr;
    fifo(1'b1, 4);
    `CHK("unselected writes", 0, nwr - n0)
    cs_n = 1'b0;
    fifo(1'b1, 4);
    `CHK("selected writes", 1, nwr - n0)
    cfg(8'hc2);
    fifo(1'b0, 12);
    n0 = nwr;
    fifo(1'b1, 12);
    `CHK("enable writes", 1'b1, (nwr - n0) > 1)
    cfg(8'hcd);
    wake_n = 1'b0;
    repeat (6) @(negedge clk);
    wake_n = 1'b1;
    `CHK("wake by pin", 1'b1, osc)
    cfg(8'hcd);
    busact = 1'b1;
    @(negedge clk);
    busact = 1'b0;
    @(negedge clk);
    `CHK("wake by activity", 1'b1, osc)
    end_sim();
  end
endmodule // usbsi_config_bank_test
